// ==== dv/iwm_fb_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// frame-buffer memory: keeps the last stored pixel and a count
module iwm_fb_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        we_i,
    input  wire logic [24:0] addr_i,
    input  wire logic [23:0] data_i,
    output logic      [15:0] count_o,
    output logic      [24:0] last_addr_o,
    output logic      [23:0] last_data_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o     <= 16'h0000;
            last_addr_o <= 25'h0000000;
            last_data_o <= 24'h000000;
        end else if (we_i) begin
            count_o     <= count_o + 16'h0001;
            last_addr_o <= addr_i;
            last_data_o <= data_i;
        end
    end
endmodule : iwm_fb_model

`default_nettype wire

// ==== dv/iwm_input_write_mode_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module iwm_input_write_mode_tb_top;
    import iwm_pkg::*;
    logic             clk_i;
    logic             rst_i;
    logic      [7:0]  addr;
    iwm_byte_t        wdata;
    logic             wr;
    logic             rd;
    logic      [7:0]  rdata;
    logic      [2:0]  disp_mode;
    logic             fmt_565;
    logic             mem_we;
    logic      [24:0] mem_addr;
    logic      [23:0] mem_data;
    logic      [15:0] fb_count;
    logic      [24:0] fb_addr;
    logic      [23:0] fb_data;
    int               num_errors = 0;
    int               num_checks = 0;
    logic      [7:0]  ofs   [10] = '{8'h52, 8'h54, 8'h56, 8'h58, 8'h5A, 8'h5C, 8'h5E, 8'h60, 8'h62, 8'h64};
    logic      [7:0]  modes [4]  = '{8'h00, 8'hF2, 8'h51, 8'hA3};

    iwm_input_write_mode dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .disp_mode_i(disp_mode), .fmt_565_i(fmt_565), .mem_we_o(mem_we),
        .mem_addr_o(mem_addr), .mem_data_o(mem_data));
    iwm_fb_model fb (.clk_i(clk_i), .rst_i(rst_i), .we_i(mem_we), .addr_i(mem_addr), .data_i(mem_data),
        .count_o(fb_count), .last_addr_o(fb_addr), .last_data_o(fb_data));

    // ============================================================
    // clock, bus tasks, checks
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr    <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd   <= 1'b0;
        #1 chk(32'(rdata), 32'(exp));
    endtask : rreg

    // 5:6:5 fields left aligned with zero low bits
    function automatic logic [23:0] x565(input logic [15:0] w);
        x565 = {w[15:11], 3'h0, w[10:5], 2'h0, w[4:0], 3'h0};
    endfunction : x565

    // one data port word, lsb then msb back to back
    task automatic pix(input logic [15:0] w, input logic we_exp, input logic [24:0] a_exp,
                       input logic [23:0] d_exp);
        logic [15:0] n0;
        n0 = fb_count;
        @(posedge clk_i);
        addr  <= 8'h66;
        wdata <= w[7:0];
        wr    <= 1'b1;
        @(posedge clk_i);
        addr  <= 8'h67;
        wdata <= w[15:8];
        @(posedge clk_i);
        wr    <= 1'b0;
        #1 chk(32'(mem_we), 32'(we_exp));
        if (we_exp) begin
            chk(32'(mem_addr), 32'(a_exp));
            chk(32'(mem_data), 32'(d_exp));
        end
        @(posedge clk_i);
        #1 chk(32'(mem_we), 32'h0);
        chk(32'(fb_count), 32'(n0 + 16'(we_exp)));
    endtask : pix

    // window x 9..16, y 8..9 from XS=XE=02, YS={01,3}, YE={02,0}
    task automatic run_win(input logic [7:0] mode, input logic [3:0] b);
        logic [9:0] col;
        logic [9:0] row;
        logic [15:0] w;
        wreg(8'h52, mode);
        for (int y = 8; y <= 9; y++) begin
            for (int x = 9; x <= 16; x++) begin
                col = (mode[1] ^ mode[0]) ? 10'(25 - x) : 10'(x);
                row = mode[0] ? 10'(17 - y) : 10'(y);
                w   = 16'(y * 64 + x) ^ 16'hA5A5;
                pix(w, 1'b1, {b, row - 10'h001, 1'b0, col - 10'h001}, x565(w));
            end
        end
    endtask : run_win

    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    initial begin
        #200000;
        num_errors++;
        results();
    end

    // ============================================================
    // tests
    initial begin
        rst_i     = 1'b1;
        addr      = 8'h00;
        wdata     = 8'h00;
        wr        = 1'b0;
        rd        = 1'b0;
        disp_mode = 3'h0;
        fmt_565   = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ofs[i]) rreg(ofs[i], 8'h00);
        rreg(8'h70, 8'h00);
        rreg(8'h68, 8'h20);
        chk(32'(mem_addr), 32'h0);
        chk(32'(fb_count), 32'h0);
        wreg(8'h5A, 8'h02);
        wreg(8'h60, 8'h02);
        wreg(8'h5C, 8'h01);
        wreg(8'h5E, 8'h03);
        wreg(8'h62, 8'h02);
        wreg(8'h64, 8'h00);
        rreg(8'h5A, 8'h02);
        rreg(8'h5E, 8'h03);
        // double buffer ignores select and alternates per window
        @(posedge clk_i) disp_mode <= 3'h1;
        run_win(8'hF0, 4'h0);
        rreg(8'h68, 8'h01);
        run_win(8'hF0, 4'h1);
        @(posedge clk_i) disp_mode <= 3'h5;
        foreach (modes[i]) run_win(modes[i], modes[i][7:4]);
        wreg(8'h52, 8'hFF);
        rreg(8'h52, 8'hFB);
        // transparency with 5:6:5 low key bits set
        wreg(8'h54, 8'h87);
        wreg(8'h56, 8'h43);
        wreg(8'h58, 8'h25);
        rreg(8'h56, 8'h43);
        wreg(8'h52, 8'h38);
        pix(16'h8204, 1'b0, 25'h0, 24'h0);
        pix(16'h1111, 1'b1, {4'h3, 10'h007, 11'h009}, x565(16'h1111));
        wreg(8'h52, 8'h30);
        pix(16'h8204, 1'b1, {4'h3, 10'h007, 11'h008}, x565(16'h8204));
        rreg(8'h66, 8'h00);
        // 8:8:8 compares full key bytes, two port words per pixel
        @(posedge clk_i) fmt_565 <= 1'b0;
        wreg(8'h52, 8'h38);
        pix(16'h8743, 1'b0, 25'h0, 24'h0);
        pix(16'h0025, 1'b0, 25'h0, 24'h0);
        pix(16'h8743, 1'b0, 25'h0, 24'h0);
        pix(16'hFF24, 1'b1, {4'h3, 10'h007, 11'h009}, 24'h874324);
        wreg(8'h52, 8'h30);
        pix(16'h8743, 1'b0, 25'h0, 24'h0);
        pix(16'h0025, 1'b1, {4'h3, 10'h007, 11'h008}, 24'h874325);
        // reset in mid-run clears registers and restarts the window
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rreg(8'h52, 8'h00);
        rreg(8'h54, 8'h00);
        rreg(8'h68, 8'h20);
        chk(32'(mem_addr), 32'h0);
        results();
    end
endmodule : iwm_input_write_mode_tb_top

`default_nettype wire

// ==== rtl/iwm_cfg.svh ====
`ifndef IWM_CFG_SVH
`define IWM_CFG_SVH

// ============================================================
// register offsets
`define IWM_OFS_MODE      8'h52
`define IWM_OFS_KEY_R     8'h54
`define IWM_OFS_KEY_G     8'h56
`define IWM_OFS_KEY_B     8'h58
`define IWM_OFS_XS        8'h5A
`define IWM_OFS_YS_HI     8'h5C
`define IWM_OFS_YS_LO     8'h5E
`define IWM_OFS_XE        8'h60
`define IWM_OFS_YE_HI     8'h62
`define IWM_OFS_YE_LO     8'h64
`define IWM_OFS_DATA_LSB  8'h66
`define IWM_OFS_DATA_MSB  8'h67
`define IWM_OFS_STATUS    8'h68

// ============================================================
// mode register fields
`define IWM_BIT_ROTATE    0
`define IWM_BIT_MIRROR    1
`define IWM_BIT_RSVD      2
`define IWM_BIT_TRANSP    3
`define IWM_BUF_MSB       7
`define IWM_BUF_LSB       4

// ============================================================
// reset values and constants
`define IWM_RST_BYTE      8'h00
`define IWM_MODE_DOUBLE   3'h1
`define IWM_X_START_ADD   11'h001
`define IWM_X_END_ADD     11'h008
`define IWM_Y_ADD         11'h001

`endif

// ==== rtl/iwm_input_write_mode.sv ====
// What this block does
// - non-double mode: writes go to selected buffer
// - buffer codes 0..15 map to buffers 1..16
// - double-buffer mode: ignore select, buffers 1/2
// - buffer select never changes displayed image
// - transparency on: skip pixels matching key colour
// - key colour matters only when transparency on
// - red key 8 bits, low 3 ignored 565
// - green key low 2 bits ignored 565
// - blue key 8 bits, low 3 ignored 565
// - mirror bit stores image horizontally mirrored
// - rotate bit stores image rotated 180 degrees
// - reserved bit 2 reads zero after reset
// - X start in 4-pixel steps, bits 7-0
// - X start pixel is byte times 4 plus 1
// - window coordinates follow displayed image orientation
// - Y start 10 bits over two registers
// - Y start row is concatenation plus one
// - X end in 4-pixel steps, bits 7-0
// - X end pixel is byte times 4 plus 8
// - Y end 10 bits over two registers plus one
// - each pixel-completing data MSB write advances memory address
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "iwm_cfg.svh"

module iwm_input_write_mode (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic [7:0]      addr_i,
    input  wire iwm_pkg::iwm_byte_t wdata_i,
    input  wire logic            wr_i,
    input  wire logic            rd_i,
    output logic      [7:0]      rdata_o,
    input  wire logic [2:0]      disp_mode_i,
    input  wire logic            fmt_565_i,
    output logic                 mem_we_o,
    output logic      [24:0]     mem_addr_o,
    output logic      [23:0]     mem_data_o
);
    import iwm_pkg::*;

    // ============================================================
    // helpers
    function automatic iwm_coord_t x_pos(input iwm_byte_t b, input iwm_coord_t add);
        x_pos = iwm_coord_t'({b, 2'b00}) + add;
    endfunction : x_pos

    function automatic iwm_coord_t y_pos(input iwm_byte_t hi, input iwm_byte_t lo);
        y_pos = iwm_coord_t'({hi, lo[1:0]}) + `IWM_Y_ADD;
    endfunction : y_pos

    function automatic iwm_coord_t flip(input iwm_coord_t lo_b, input iwm_coord_t hi_b, input iwm_coord_t p);
        flip = iwm_coord_t'(hi_b + lo_b - p);
    endfunction : flip

    // ============================================================
    // registers
    logic [3:0] buf_sel;
    logic       transp_en;
    logic       mirror_en;
    logic       rotate_en;
    iwm_byte_t  key_r;
    iwm_byte_t  key_g;
    iwm_byte_t  key_b;
    iwm_byte_t  xs_reg;
    iwm_byte_t  ys_hi;
    iwm_byte_t  ys_lo;
    iwm_byte_t  xe_reg;
    iwm_byte_t  ye_hi;
    iwm_byte_t  ye_lo;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_sel   <= 4'h0;
            transp_en <= 1'b0;
            mirror_en <= 1'b0;
            rotate_en <= 1'b0;
        end else if (wr_i && addr_i == `IWM_OFS_MODE) begin
            buf_sel   <= wdata_i[`IWM_BUF_MSB:`IWM_BUF_LSB];
            transp_en <= wdata_i[`IWM_BIT_TRANSP];
            mirror_en <= wdata_i[`IWM_BIT_MIRROR];
            rotate_en <= wdata_i[`IWM_BIT_ROTATE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_r <= `IWM_RST_BYTE;
            key_g <= `IWM_RST_BYTE;
            key_b <= `IWM_RST_BYTE;
        end else if (wr_i) begin
            if (addr_i == `IWM_OFS_KEY_R) key_r <= wdata_i;
            if (addr_i == `IWM_OFS_KEY_G) key_g <= wdata_i;
            if (addr_i == `IWM_OFS_KEY_B) key_b <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xs_reg <= `IWM_RST_BYTE;
            ys_hi  <= `IWM_RST_BYTE;
            ys_lo  <= `IWM_RST_BYTE;
            xe_reg <= `IWM_RST_BYTE;
            ye_hi  <= `IWM_RST_BYTE;
            ye_lo  <= `IWM_RST_BYTE;
        end else if (wr_i) begin
            if (addr_i == `IWM_OFS_XS)    xs_reg <= wdata_i;
            if (addr_i == `IWM_OFS_YS_HI) ys_hi  <= wdata_i;
            if (addr_i == `IWM_OFS_YS_LO) ys_lo  <= {6'h00, wdata_i[1:0]};
            if (addr_i == `IWM_OFS_XE)    xe_reg <= wdata_i;
            if (addr_i == `IWM_OFS_YE_HI) ye_hi  <= wdata_i;
            if (addr_i == `IWM_OFS_YE_LO) ye_lo  <= {6'h00, wdata_i[1:0]};
        end
    end

    // ============================================================
    // window bounds, 1-based display coordinates
    iwm_coord_t win_xs;
    iwm_coord_t win_xe;
    iwm_coord_t win_ys;
    iwm_coord_t win_ye;

    assign win_xs = x_pos(xs_reg, `IWM_X_START_ADD);
    assign win_xe = x_pos(xe_reg, `IWM_X_END_ADD);
    assign win_ys = y_pos(ys_hi, ys_lo);
    assign win_ye = y_pos(ye_hi, ye_lo);

    // ============================================================
    // data port word and pixel assembly
    logic       win_wr;
    logic       word_fire;
    logic       pix_fire;
    logic [7:0] lsb_hold;
    logic [15:0] word;
    iwm_phase_t phase;
    iwm_byte_t  hold_r;
    iwm_byte_t  hold_g;
    iwm_byte_t  px_r;
    iwm_byte_t  px_g;
    iwm_byte_t  px_b;

    assign win_wr    = wr_i && (addr_i == `IWM_OFS_MODE || addr_i == `IWM_OFS_XS ||
                       addr_i == `IWM_OFS_YS_HI || addr_i == `IWM_OFS_YS_LO ||
                       addr_i == `IWM_OFS_XE || addr_i == `IWM_OFS_YE_HI || addr_i == `IWM_OFS_YE_LO);
    assign word_fire = wr_i && addr_i == `IWM_OFS_DATA_MSB;
    assign word      = {wdata_i, lsb_hold};
    assign pix_fire  = word_fire && (fmt_565_i || phase == IWM_PH_SECOND);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lsb_hold <= 8'h00;
        end else if (wr_i && addr_i == `IWM_OFS_DATA_LSB) begin
            lsb_hold <= wdata_i;
        end
    end

    // 8:8:8 takes {red,green} then {-,blue}; window writes resync the phase
    always_ff @(posedge clk_i) begin
        if (rst_i || win_wr || fmt_565_i) begin
            phase <= IWM_PH_FIRST;
        end else if (word_fire) begin
            phase <= (phase == IWM_PH_FIRST) ? IWM_PH_SECOND : IWM_PH_FIRST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_r <= 8'h00;
            hold_g <= 8'h00;
        end else if (word_fire && phase == IWM_PH_FIRST) begin
            hold_r <= word[15:8];
            hold_g <= word[7:0];
        end
    end

    always_comb begin
        if (fmt_565_i) begin
            px_r = {word[15:11], 3'h0};
            px_g = {word[10:5], 2'h0};
            px_b = {word[4:0], 3'h0};
        end else begin
            px_r = hold_r;
            px_g = hold_g;
            px_b = word[7:0];
        end
    end

    // ============================================================
    // transparency key compare
    logic key_hit;
    logic skip_px;

    always_comb begin
        if (fmt_565_i) begin
            key_hit = px_r[7:3] == key_r[7:3] && px_g[7:2] == key_g[7:2] && px_b[7:3] == key_b[7:3];
        end else begin
            key_hit = px_r == key_r && px_g == key_g && px_b == key_b;
        end
    end

    assign skip_px = transp_en && key_hit;

    // ============================================================
    // raster cursor over the window
    logic       restart;
    iwm_coord_t cur_x;
    iwm_coord_t cur_y;
    iwm_coord_t pos_x;
    iwm_coord_t pos_y;
    logic       last_x;
    logic       last_y;
    logic       db_half;

    assign pos_x  = restart ? win_xs : cur_x;
    assign pos_y  = restart ? win_ys : cur_y;
    assign last_x = pos_x >= win_xe;
    assign last_y = pos_y >= win_ye;

    always_ff @(posedge clk_i) begin
        if (rst_i || win_wr) begin
            restart <= 1'b1;
        end else if (pix_fire) begin
            restart <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_x <= `IWM_X_START_ADD;
            cur_y <= `IWM_Y_ADD;
        end else if (pix_fire) begin
            if (last_x) begin
                cur_x <= win_xs;
                cur_y <= last_y ? win_ys : iwm_coord_t'(pos_y + `IWM_Y_ADD);
            end else begin
                cur_x <= iwm_coord_t'(pos_x + 11'h001);
                cur_y <= pos_y;
            end
        end
    end

    // double-buffer mode alternates buffers 1 and 2 per completed window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            db_half <= 1'b0;
        end else if (pix_fire && last_x && last_y && disp_mode_i == `IWM_MODE_DOUBLE) begin
            db_half <= ~db_half;
        end
    end

    // ============================================================
    // stored position: flips stay inside the window, bounds follow the shown image
    logic [3:0] eff_buf;
    iwm_coord_t st_x;
    iwm_coord_t st_y;

    assign eff_buf = (disp_mode_i == `IWM_MODE_DOUBLE) ? {3'h0, db_half} : buf_sel;
    assign st_x    = (mirror_en ^ rotate_en) ? flip(win_xs, win_xe, pos_x) : pos_x;
    assign st_y    = rotate_en ? flip(win_ys, win_ye, pos_y) : pos_y;

    // only the write address and the mode and status readback see the buffer code; no display selection here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_we_o   <= 1'b0;
            mem_addr_o <= 25'h0000000;
            mem_data_o <= 24'h000000;
        end else begin
            mem_we_o <= pix_fire && !skip_px;
            if (pix_fire) begin
                mem_addr_o <= {eff_buf, st_y[9:0] - 10'h001, st_x - 11'h001};
                mem_data_o <= {px_r, px_g, px_b};
            end
        end
    end

    // ============================================================
    // register readback
    logic [7:0] next_rdata;

    always_comb begin
        unique case (addr_i)
            `IWM_OFS_MODE:   next_rdata = {buf_sel, transp_en, 1'b0, mirror_en, rotate_en};
            `IWM_OFS_KEY_R:  next_rdata = key_r;
            `IWM_OFS_KEY_G:  next_rdata = key_g;
            `IWM_OFS_KEY_B:  next_rdata = key_b;
            `IWM_OFS_XS:     next_rdata = xs_reg;
            `IWM_OFS_YS_HI:  next_rdata = ys_hi;
            `IWM_OFS_YS_LO:  next_rdata = ys_lo;
            `IWM_OFS_XE:     next_rdata = xe_reg;
            `IWM_OFS_YE_HI:  next_rdata = ye_hi;
            `IWM_OFS_YE_LO:  next_rdata = ye_lo;
            `IWM_OFS_STATUS: next_rdata = {2'h0, restart, phase, eff_buf};
            default:         next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? next_rdata : 8'h00;
        end
    end

    // ============================================================
    // assertions
    property p_buf_sel;
        @(posedge clk_i) disable iff (rst_i)
        pix_fire && !skip_px && disp_mode_i != `IWM_MODE_DOUBLE |=> mem_addr_o[24:21] == $past(buf_sel);
    endproperty
    a_buf_sel: assert property (p_buf_sel) else $error("write landed in wrong buffer");

    property p_double_buf;
        @(posedge clk_i) disable iff (rst_i)
        pix_fire && disp_mode_i == `IWM_MODE_DOUBLE |=> mem_addr_o[24:22] == 3'h0;
    endproperty
    a_double_buf: assert property (p_double_buf) else $error("double mode used buffer above two");

    property p_transp_skip;
        @(posedge clk_i) disable iff (rst_i)
        word_fire && fmt_565_i && transp_en && word == {key_r[7:3], key_g[7:2], key_b[7:3]} |=> !mem_we_o;
    endproperty
    a_transp_skip: assert property (p_transp_skip) else $error("key pixel was written");

    property p_transp_off;
        @(posedge clk_i) disable iff (rst_i)
        pix_fire && !transp_en |=> mem_we_o;
    endproperty
    a_transp_off: assert property (p_transp_off) else $error("pixel dropped with transparency off");

    property p_no_flip;
        @(posedge clk_i) disable iff (rst_i)
        pix_fire && !mirror_en && !rotate_en |=> mem_addr_o[10:0] == $past(pos_x) - 11'h001;
    endproperty
    a_no_flip: assert property (p_no_flip) else $error("column moved without flip");

    property p_rotate_row;
        @(posedge clk_i) disable iff (rst_i)
        pix_fire && rotate_en && restart |=> mem_addr_o[20:11] == $past(win_ye[9:0]) - 10'h001;
    endproperty
    a_rotate_row: assert property (p_rotate_row) else $error("rotated first pixel not on last row");

    property p_rsvd_read;
        @(posedge clk_i) disable iff (rst_i)
        rd_i && addr_i == `IWM_OFS_MODE |=> rdata_o[`IWM_BIT_RSVD] == 1'b0;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bit read as one");

    property p_in_window;
        @(posedge clk_i) disable iff (rst_i)
        mem_we_o |-> mem_addr_o[10:0] >= win_xs - 11'h001 && mem_addr_o[10:0] <= win_xe - 11'h001;
    endproperty
    a_in_window: assert property (p_in_window) else $error("write outside window columns");

    property p_raster;
        @(posedge clk_i) disable iff (rst_i)
        pix_fire && !last_x |=> cur_x == $past(pos_x) + 11'h001 && cur_y == $past(pos_y);
    endproperty
    a_raster: assert property (p_raster) else $error("cursor did not step right");

    c_write:  cover property (@(posedge clk_i) disable iff (rst_i) mem_we_o);
    c_skip:   cover property (@(posedge clk_i) disable iff (rst_i) pix_fire && skip_px);
    c_rotate: cover property (@(posedge clk_i) disable iff (rst_i) pix_fire && rotate_en && last_x && last_y);

endmodule : iwm_input_write_mode

`default_nettype wire

// ==== rtl/iwm_pkg.sv ====
`default_nettype none

package iwm_pkg;

    // pixel assembly phase for 8:8:8 input (two port words per pixel)
    typedef enum logic [0:0] {
        IWM_PH_FIRST  = 1'b0,
        IWM_PH_SECOND = 1'b1
    } iwm_phase_t;

    typedef logic [10:0] iwm_coord_t;
    typedef logic [7:0]  iwm_byte_t;

endpackage : iwm_pkg

`default_nettype wire
